// [hdl/dac_ctrl_pkg.sv]
package dac_ctrl_pkg;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam int CODE_W = 10;
    localparam int CODE_FULL_SCALE = 1024;
    localparam int BIT_ON = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_SLEEP_HOLD = 12;
    localparam int BIT_JUSTIFY = 11;
    localparam int BIT_TRIG_GATE = 8;
    localparam int BIT_PIN_DRIVE = 7;
    localparam int TSEL_LSB = 2;
    localparam int REF_LSB = 0;
    localparam logic [15:0] CONTROL_WMASK = 16'hb9ff;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [4:0] TSEL_LAST = 5'h11;
    localparam logic [4:0] TSEL_HOLE = 5'h09;
    localparam logic [1:0] REF_NONE = 2'h0;
    localparam logic [1:0] REF_BANDGAP = 2'h3;
endpackage : dac_ctrl_pkg

// [hdl/dac_trig_select.sv]
`timescale 1ns/1ps
module dac_trig_select (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [4:0] sel_i,
    input wire logic [17:0] events_i,
    output logic fire_o
);
    typedef struct packed {
        logic fire;
    } sel_state_t;
    sel_state_t st_r;
    sel_state_t st_nxt;

    always_comb
    begin
        st_nxt.fire = 1'b0;
        // Holes and codes above the last source never fire.
        if (sel_i <= dac_ctrl_pkg::TSEL_LAST && sel_i != dac_ctrl_pkg::TSEL_HOLE)
        begin
            st_nxt.fire = events_i[sel_i];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
            st_r <= '0;
        else if (clk_en_i)
            st_r <= st_nxt;
    end

    assign fire_o = st_r.fire;

    a_hole_silent: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && (sel_i == dac_ctrl_pkg::TSEL_HOLE || sel_i > dac_ctrl_pkg::TSEL_LAST)) |=> !fire_o)
        else $error("unimplemented trigger code fired");
endmodule : dac_trig_select

// [hdl/dac_code_align.sv]
`timescale 1ns/1ps
module dac_code_align (
    input wire logic [15:0] word_i,
    input wire logic left_i,
    output logic [9:0] code_o
);
    // Pure alignment mux; the caller registers the result.
    assign code_o = left_i ? word_i[15:6] : word_i[9:0];
endmodule : dac_code_align

// [hdl/dac_control_trigger.sv]
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dac_control_trigger #(
    parameter int CODE_W = dac_ctrl_pkg::CODE_W
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [15:0] avs_writedata_i,
    output logic [15:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic idle_mode_i,
    input wire logic sleep_mode_i,
    input wire logic [2:0] comparator_trig_i,
    input wire logic adc_done_i,
    input wire logic [4:0] timer_match_i,
    input wire logic multi_output_capcomp_one_i,
    input wire logic [5:0] single_output_capcomp_i,
    input wire logic external_irq_one_i,
    output logic [CODE_W-1:0] ladder_code_o,
    output logic ladder_power_o,
    output logic pin_drive_enable_o,
    output logic [1:0] reference_sel_o,
    output logic bandgap_enable_o
);
    typedef struct packed {
        logic [15:0] control;
        logic [15:0] data;
        logic pending;
        logic [CODE_W-1:0] code;
        logic power;
        logic pin_oe;
        logic [1:0] ref_sel;
        logic bandgap;
        logic [15:0] rdata;
        logic ack;
    } dac_state_t;

    dac_state_t st_r;
    dac_state_t st_nxt;
    logic [9:0] aligned_code;
    logic trig_fire;
    logic [17:0] events;
    logic conv_on;
    logic running;
    logic sleeping_off;
    logic data_wr;
    logic wait_now;

    // The index of each event is its trigger code; code 9 has no source.
    assign events = {external_irq_one_i, single_output_capcomp_i, multi_output_capcomp_one_i, 1'b0,
                     timer_match_i, adc_done_i, comparator_trig_i};

    dac_trig_select u_trig (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .sel_i(st_r.control[6:2]),
        .events_i(events),
        .fire_o(trig_fire)
    );

    dac_code_align u_align (
        .word_i(st_r.data),
        .left_i(st_r.control[dac_ctrl_pkg::BIT_JUSTIFY]),
        .code_o(aligned_code)
    );

    // One wait cycle per access gives a registered read path.
    assign wait_now = (avs_read_i || avs_write_i) && !st_r.ack;
    assign avs_waitrequest_o = wait_now;
    assign data_wr = avs_write_i && st_r.ack && avs_address_i == dac_ctrl_pkg::ADDR_DATA;

    assign conv_on = st_r.control[dac_ctrl_pkg::BIT_ON]
                     && st_r.control[1:0] != dac_ctrl_pkg::REF_NONE;
    assign sleeping_off = sleep_mode_i && !st_r.control[dac_ctrl_pkg::BIT_SLEEP_HOLD];
    assign running = conv_on && !(idle_mode_i && st_r.control[dac_ctrl_pkg::BIT_IDLE_STOP])
                     && !sleeping_off;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        if ((avs_read_i || avs_write_i) && !st_r.ack)
        begin
            st_nxt.ack = 1'b1;
            if (!avs_write_i)
            begin
                unique case (avs_address_i)
                    dac_ctrl_pkg::ADDR_CONTROL: st_nxt.rdata = st_r.control;
                    dac_ctrl_pkg::ADDR_DATA: st_nxt.rdata = st_r.data;
                    dac_ctrl_pkg::ADDR_STATUS: st_nxt.rdata = {13'h0000, st_r.pending, st_r.power, running};
                    default: st_nxt.rdata = 16'h0000;
                endcase
            end
        end
        // A write lands only at the edge where the master sees waitrequest low, so an aborted request changes nothing.
        if (avs_write_i && st_r.ack)
        begin
            if (avs_address_i == dac_ctrl_pkg::ADDR_CONTROL)
                st_nxt.control = avs_writedata_i & dac_ctrl_pkg::CONTROL_WMASK;
            else if (avs_address_i == dac_ctrl_pkg::ADDR_DATA)
                st_nxt.data = avs_writedata_i;
        end
        // A written word waits for the selected event in trigger mode.
        if (st_r.control[dac_ctrl_pkg::BIT_TRIG_GATE])
        begin
            if (trig_fire && running)
            begin
                st_nxt.code = aligned_code;
                st_nxt.pending = data_wr;
            end
            else if (data_wr)
                st_nxt.pending = 1'b1;
        end
        else
        begin
            st_nxt.pending = 1'b0;
            if (running)
                st_nxt.code = aligned_code;
        end
        st_nxt.power = running;
        st_nxt.pin_oe = running && st_r.control[dac_ctrl_pkg::BIT_PIN_DRIVE];
        st_nxt.ref_sel = st_r.control[1:0];
        st_nxt.bandgap = st_r.control[dac_ctrl_pkg::BIT_ON];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= '0;
        end
        else if (clk_en_i)
        begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata_o = st_r.rdata;
    assign ladder_code_o = st_r.code;
    assign ladder_power_o = st_r.power;
    assign pin_drive_enable_o = st_r.pin_oe;
    assign reference_sel_o = st_r.ref_sel;
    assign bandgap_enable_o = st_r.bandgap;

    sequence s_stopped;
        clk_en_i && !running;
    endsequence

    a_off_no_power: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !st_r.control[dac_ctrl_pkg::BIT_ON]) |=> !ladder_power_o)
        else $error("powered while disabled");
    a_idle_halts: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && idle_mode_i && st_r.control[dac_ctrl_pkg::BIT_IDLE_STOP]) |=> !ladder_power_o)
        else $error("running in idle with stop set");
    a_sleep_release: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && sleeping_off) |=> (!ladder_power_o && !pin_drive_enable_o))
        else $error("pin driven in sleep");
    a_stop_no_oe: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_stopped |=> !pin_drive_enable_o)
        else $error("pin driven while stopped");
    a_ref_none_off: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && st_r.control[1:0] == dac_ctrl_pkg::REF_NONE) |=> !ladder_power_o)
        else $error("converting with no reference");
    a_bandgap_follow: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i |=> bandgap_enable_o == $past(st_r.control[dac_ctrl_pkg::BIT_ON]))
        else $error("band gap not tracking enable");
    a_unimpl_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (st_r.control & ~dac_ctrl_pkg::CONTROL_WMASK) == 16'h0000)
        else $error("unimplemented control bit set");
    a_gate_holds: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && st_r.control[dac_ctrl_pkg::BIT_TRIG_GATE] && !trig_fire) |=> $stable(ladder_code_o))
        else $error("code moved without trigger");
    a_free_update: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && running && !st_r.control[dac_ctrl_pkg::BIT_TRIG_GATE]) |=> ladder_code_o == $past(aligned_code))
        else $error("code not following data");

    sequence s_write_control;
        clk_en_i && avs_write_i && st_r.ack && avs_address_i == dac_ctrl_pkg::ADDR_CONTROL;
    endsequence

    sequence s_gated_load;
        clk_en_i && st_r.control[dac_ctrl_pkg::BIT_TRIG_GATE] && trig_fire && running;
    endsequence

    a_write_on_ack: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_write_control |=> st_r.control == $past(avs_writedata_i & dac_ctrl_pkg::CONTROL_WMASK))
        else $error("control write not taken on answer");
    a_read_zero_bits: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && avs_read_i && !st_r.ack && avs_address_i == dac_ctrl_pkg::ADDR_CONTROL)
        |=> (avs_readdata_o & ~dac_ctrl_pkg::CONTROL_WMASK) == 16'h0000)
        else $error("unimplemented bit read as one");
    a_one_wait: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && (avs_read_i || avs_write_i) && !st_r.ack) |=> st_r.ack)
        else $error("answer not given after one wait");
    a_trig_loads: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_gated_load |=> ladder_code_o == $past(aligned_code))
        else $error("trigger did not load code");
    a_pending_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && st_r.control[dac_ctrl_pkg::BIT_TRIG_GATE] && data_wr && !(trig_fire && running))
        |=> st_r.pending)
        else $error("written word not held pending");
    a_ref_follow: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i |=> reference_sel_o == $past(st_r.control[1:0]))
        else $error("reference select not following control");
    a_oe_follow: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        clk_en_i |=> pin_drive_enable_o == $past(running && st_r.control[dac_ctrl_pkg::BIT_PIN_DRIVE]))
        else $error("pin drive not following control");
    a_sleep_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && sleep_mode_i && st_r.control[dac_ctrl_pkg::BIT_SLEEP_HOLD] && conv_on
        && !(idle_mode_i && st_r.control[dac_ctrl_pkg::BIT_IDLE_STOP])) |=> ladder_power_o)
        else $error("converter stopped in sleep with hold set");
    a_off_code_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (clk_en_i && !running) |=> $stable(ladder_code_o))
        else $error("code moved while stopped");
    a_freeze_all: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !clk_en_i |=> $stable(st_r))
        else $error("state moved with clock enable low");
endmodule : dac_control_trigger

// [bench/dac_ladder_model.sv]
`timescale 1ns/1ps
module dac_ladder_model #(
    parameter int SUPPLY_MV = 3300,
    parameter int EXT_REF_MV = 2000
) (
    input wire logic [9:0] code_i,
    input wire logic power_i,
    input wire logic drive_i,
    input wire logic [1:0] ref_i,
    output int level_mv_o,
    output logic driven_o
);
    int ref_mv;
    always_comb
    begin
        case (ref_i)
            2'h3: ref_mv = 2400;
            2'h2: ref_mv = SUPPLY_MV;
            2'h1: ref_mv = EXT_REF_MV;
            default: ref_mv = 0;
        endcase
        // An unpowered ladder gives no level, so a stale code never reads as valid.
        level_mv_o = power_i ? ref_mv * int'(code_i) / 1024 : 0;
        // The pin is taken as already set to analog with its direction chosen by software.
        driven_o = drive_i & power_i;
    end
endmodule : dac_ladder_model

// [bench/dac_control_trigger_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module dac_control_trigger_tb_top;
    logic core_clk_i = 0, rst_b_i = 0, rd_r = 0, wr_r = 0, idle_r = 0, sleep_r = 0;
    logic [3:0] adr_r = 0;
    logic [15:0] wd_r = 0, rdata, rdv;
    logic [17:0] ev = 0;
    logic [9:0] code, exp_code;
    logic pwr, bg, wreq, drv, oe;
    logic en_r = 1;
    logic [1:0] rsel;
    int bad_count = 0, n_checks = 0, lvl;
    // Columns: control word, data word, {expected power, 5'h0, expected code}.
    logic [15:0] rows [6][3] = '{'{16'h8083, 16'h03ff, 16'h83ff}, '{16'h8803, 16'hffc0, 16'h83ff},
        '{16'h8881, 16'h8040, 16'h8201}, '{16'h8002, 16'h02aa, 16'h82aa},
        '{16'h8000, 16'h0155, 16'h0000}, '{16'h0003, 16'h0155, 16'h0000}};
    dac_control_trigger dac_control_trigger_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(en_r),
        .avs_address_i(adr_r), .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wd_r),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .idle_mode_i(idle_r), .sleep_mode_i(sleep_r),
        .comparator_trig_i(ev[2:0]), .adc_done_i(ev[3]), .timer_match_i(ev[8:4]),
        .multi_output_capcomp_one_i(ev[10]), .single_output_capcomp_i(ev[16:11]), .external_irq_one_i(ev[17]),
        .ladder_code_o(code), .ladder_power_o(pwr), .pin_drive_enable_o(oe), .reference_sel_o(rsel),
        .bandgap_enable_o(bg));
    dac_ladder_model dac_ladder_model_i (.code_i(code), .power_i(pwr),
        .drive_i(oe), .ref_i(rsel), .level_mv_o(lvl), .driven_o(drv));
    task automatic print_verdict;
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // Waitrequest only changes on a rising edge, so its level at the falling edge is what the next edge samples.
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n = 0;
        @(posedge core_clk_i);
        wr_r <= w;
        rd_r <= !w;
        adr_r <= a;
        wd_r <= d;
        do
        begin
            @(negedge core_clk_i);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        if (wreq !== 1'b0)
        begin
            bad_count++;
            print_verdict();
        end
        rdv = rdata;
        @(posedge core_clk_i);
        wr_r <= 1'b0;
        rd_r <= 1'b0;
    endtask : bus
    task automatic settle;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask : settle
    task automatic pulse(input logic [17:0] e);
        @(posedge core_clk_i);
        ev <= e;
        @(posedge core_clk_i);
        ev <= '0;
        settle();
    endtask : pulse
    initial
    begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(negedge core_clk_i);
        `CHK({code, pwr, bg, rsel}, 14'h0000)
        bus(1'b0, 4'h0, 16'h0000);
        `CHK(rdv, 16'h0000)
        bus(1'b1, 4'h0, 16'hffff);
        bus(1'b0, 4'h0, 16'h0000);
        `CHK(rdv, 16'hb9ff)
        bus(1'b0, 4'hc, 16'h0000);
        `CHK(rdv, 16'h0000)
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, 4'h0, rows[i][0]);
            bus(1'b1, 4'h4, rows[i][1]);
            settle();
            `CHK(pwr, rows[i][2][15])
            if (rows[i][2][15]) `CHK(code, rows[i][2][9:0])
            `CHK(bg, rows[i][0][15])
            `CHK(drv, rows[i][0][7] & rows[i][2][15])
            `CHK(rsel, rows[i][0][1:0])
            if (rows[i][0][1:0] == 2'h3 && rows[i][2][15]) `CHK(lvl, 2400 * int'(rows[i][2][9:0]) / 1024)
        end
        bus(1'b1, 4'h0, 16'ha083);
        idle_r <= 1'b1;
        settle();
        `CHK(pwr, 1'b0)
        // With the clock enable low, leaving idle must not restart the converter.
        @(posedge core_clk_i);
        en_r <= 1'b0;
        idle_r <= 1'b0;
        settle();
        `CHK(pwr, 1'b0)
        @(posedge core_clk_i);
        en_r <= 1'b1;
        idle_r <= 1'b1;
        bus(1'b1, 4'h0, 16'h8083);
        settle();
        `CHK(pwr, 1'b1)
        idle_r <= 1'b0;
        sleep_r <= 1'b1;
        settle();
        `CHK({pwr, drv}, 2'b00)
        bus(1'b1, 4'h0, 16'h9083);
        settle();
        `CHK({pwr, drv}, 2'b11)
        sleep_r <= 1'b0;
        bus(1'b1, 4'h4, 16'h0000);
        settle();
        exp_code = 10'h000;
        for (int s = 0; s < 32; s++)
        begin
            bus(1'b1, 4'h0, {8'h81, 1'b0, 5'(s), 2'b11});
            bus(1'b1, 4'h4, 16'(s + 1));
            settle();
            `CHK(code, exp_code)
            bus(1'b0, 4'h8, 16'h0000);
            `CHK(rdv, 16'h0007)
            if (s < 18 && s != 9)
            begin
                pulse(~(18'h00001 << s));
                `CHK(code, exp_code)
                pulse(18'h00001 << s);
                exp_code = 10'(s + 1);
            end
            else
                pulse('1);
            `CHK(code, exp_code)
        end
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(negedge core_clk_i);
        `CHK({code, pwr, bg, rsel}, 14'h0000)
        bus(1'b0, 4'h0, 16'h0000);
        `CHK(rdv, 16'h0000)
        print_verdict();
    end
endmodule : dac_control_trigger_tb_top
